// ==== core/rcb_pkg.sv ====
// Constants shared by the regulator control register bank.
//
// Operation
// R1 - Frequency bit plus range bit pick 2/3/4 MHz.
// R2 - Buck voltage code zero powers converter down.
// R3 - Buck code decodes in three linear segments.
// R4 - Linear code: zero off, gap codes forbidden.
// R5 - Linear limit bit selects 150 or 300 mA.
// R6 - Inversion bit inverts pin input or output.
// R7 - Special-function field selects the pin role.
// R8 - Single voltage-select pin drives both slots.
// R9 - Mode field selects pin electrical mode, reset 3.
// R10 - Global enable bit, reset one, forces rail off.
// R11 - Output-data bit sets driven pin level.
// R12 - Input-data bit reads pin level, read-only.
// R13 - Active select pin substitutes slot-one preset byte.
// R14 - Target selector resets ones; 0Ch up disables.
// R15 - Preset byte is a full register image.
// R16 - Slot-two preset goes to slot-two target.
// R17 - Pin release restores own setting; reserved read zero.
// R18 - Serial word address auto-increments per byte.
package rcb_pkg;

	localparam int NUM_BUCK = 5;
	localparam int NUM_LIN  = 2;
	localparam int NUM_RAIL = 7;
	localparam int NUM_PIN  = 2;

	localparam logic [7:0] OFF_LEVEL_FIRST = 8'h00;
	localparam logic [7:0] OFF_LEVEL_LAST  = 8'h06;
	localparam logic [7:0] OFF_PIN1_CFG    = 8'h0c;
	localparam logic [7:0] OFF_PIN2_CFG    = 8'h0d;
	localparam logic [7:0] OFF_RAIL_EN     = 8'h10;
	localparam logic [7:0] OFF_PIN_OUT     = 8'h20;
	localparam logic [7:0] OFF_PIN_IN      = 8'h21;
	localparam logic [7:0] OFF_PRESET1     = 8'h22;
	localparam logic [7:0] OFF_PRESET2     = 8'h23;
	localparam logic [7:0] OFF_TARGETS     = 8'h24;

	localparam logic [7:0] RST_LEVEL   = 8'h00;
	localparam logic [7:0] RST_PIN_CFG = 8'h03;
	localparam logic [6:0] RST_RAIL_EN = 7'h7f;
	localparam logic [1:0] RST_PIN_OUT = 2'h0;
	localparam logic [7:0] RST_PRESET  = 8'h00;
	localparam logic [7:0] RST_TARGETS = 8'hff;

	localparam int CFG_INV_BIT  = 7;
	localparam int CFG_FUNC_LSB = 3;
	localparam int CFG_MODE_LSB = 0;
	localparam int LEVEL_TOP    = 7;
	localparam int TGT1_LSB     = 0;
	localparam int TGT2_LSB     = 4;
	localparam logic [3:0] TGT_LIMIT = 4'hc;

	localparam logic [2:0] MODE_IN      = 3'h0;
	localparam logic [2:0] MODE_PP      = 3'h1;
	localparam logic [2:0] MODE_OD      = 3'h2;
	localparam logic [2:0] MODE_IN_PU   = 3'h4;
	localparam logic [2:0] MODE_IN_PD   = 3'h5;
	localparam logic [2:0] MODE_OD_PU   = 3'h6;

	localparam logic [3:0] FUNC_IO      = 4'h0;
	localparam logic [3:0] FUNC_IRQ_OUT = 4'h1;
	localparam logic [3:0] FUNC_SUP_LOW = 4'h2;
	localparam logic [3:0] FUNC_IRQ_IN  = 4'h3;
	localparam logic [3:0] FUNC_VSEL    = 4'h5;
	localparam logic [3:0] FUNC_STBY    = 4'h6;
	localparam logic [3:0] FUNC_PGOOD   = 4'h7;

	localparam logic [1:0] FREQ_2MHZ = 2'h0;
	localparam logic [1:0] FREQ_3MHZ = 2'h1;
	localparam logic [1:0] FREQ_4MHZ = 2'h2;

	// Voltages are in units of 0.1 mV.
	localparam logic [6:0]  BUCK_SEG2 = 7'h41;
	localparam logic [6:0]  BUCK_SEG3 = 7'h71;
	localparam logic [6:0]  BUCK_OFS2 = 7'h40;
	localparam logic [6:0]  BUCK_OFS3 = 7'h70;
	localparam logic [15:0] BUCK_B1   = 16'h1770;
	localparam logic [15:0] BUCK_S1   = 16'h007d;
	localparam logic [15:0] BUCK_B2   = 16'h36b0;
	localparam logic [15:0] BUCK_S2   = 16'h00fa;
	localparam logic [15:0] BUCK_B3   = 16'h6590;
	localparam logic [15:0] BUCK_S3   = 16'h01f4;
	localparam logic [6:0]  LIN_GAP_LO = 7'h25;
	localparam logic [6:0]  LIN_HI_OFS = 7'h40;
	localparam logic [15:0] LIN_B1     = 16'h1f40;
	localparam logic [15:0] LIN_B2     = 16'h4362;
	localparam logic [15:0] LIN_STEP   = 16'h00fa;

endpackage

// ==== core/rcb_pin_ctl.sv ====
// Electrical mode, inversion and special-function logic of one pin.
`timescale 1ns/1ps
module rcb_pin_ctl
	import rcb_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic [7:0] cfg,
	input  wire logic       drive_value,
	input  wire logic       irq_level,
	input  wire logic       supply_low,
	input  wire logic       power_good,
	input  wire logic       pin_in,
	output logic            pin_out,
	output logic            pin_oe_n,
	output logic            pull_up,
	output logic            pull_down,
	output logic            sampled_level,
	output logic            vsel_active,
	output logic            irq_in,
	output logic            standby_in
);

	wire       inv     = cfg[CFG_INV_BIT];
	wire [3:0] func    = cfg[CFG_FUNC_LSB +: 4];
	wire [2:0] mode    = cfg[CFG_MODE_LSB +: 3];
	wire       is_pp   = (mode == MODE_PP);
	wire       is_od   = (mode == MODE_OD) || (mode == MODE_OD_PU);
	wire       is_in   = (mode == MODE_IN) || (mode == MODE_IN_PU) ||
	                     (mode == MODE_IN_PD) || is_od;
	wire       src     = (func == FUNC_IRQ_OUT) ? irq_level :
	                     (func == FUNC_SUP_LOW) ? supply_low :
	                     (func == FUNC_PGOOD)   ? power_good :
	                     drive_value; // [R7] [R11]
	wire       lvl_out = src ^ inv; // [R6]
	// Open drain releases the pin for a high level.
	wire       oe_nxt  = is_pp ? 1'b0 : is_od ? lvl_out : 1'b1; // [R9]
	wire       out_nxt = is_pp ? lvl_out : 1'b0;
	logic      pin_out_r;
	logic      pin_oe_n_r;
	logic      level_r;

	always_ff @(posedge mclk) begin
		if (rst) begin
			pin_out_r  <= 1'b0;
			pin_oe_n_r <= 1'b1;
			level_r    <= 1'b0;
		end else begin
			pin_out_r  <= out_nxt;
			pin_oe_n_r <= oe_nxt;
			level_r    <= is_in ? (pin_in ^ inv) : 1'b0; // [R6] [R12]
		end
	end

	assign pin_out       = pin_out_r;
	assign pin_oe_n      = pin_oe_n_r;
	assign pull_up       = (mode == MODE_IN_PU) || (mode == MODE_OD_PU);
	assign pull_down     = (mode == MODE_IN_PD);
	assign sampled_level = level_r;
	assign vsel_active   = (func == FUNC_VSEL) || (func == FUNC_STBY); // [R7]
	assign irq_in        = (func == FUNC_IRQ_IN) && level_r;
	assign standby_in    = (func == FUNC_STBY) && level_r;

	a_pp_drive: assert property (@(posedge mclk) disable iff (rst) // [R9]
		is_pp |=> !pin_oe_n && (pin_out == $past(lvl_out)))
		else $error("push-pull pin not driven");
	a_inv_out: assert property (@(posedge mclk) disable iff (rst) // [R6]
		(is_pp && func == FUNC_IO) |=>
		pin_out == ($past(drive_value) ^ $past(inv)))
		else $error("inversion not applied to output");

endmodule // rcb_pin_ctl

// ==== core/rcb_remap.sv ====
// Substitutes preset bytes into the selected regulator settings.
`timescale 1ns/1ps
module rcb_remap
	import rcb_pkg::*;
#(
	parameter int N_RAIL = NUM_RAIL
) (
	input  wire logic [N_RAIL-1:0][7:0] own_byte,
	input  wire logic [7:0]             preset1,
	input  wire logic [7:0]             preset2,
	input  wire logic [3:0]             target1,
	input  wire logic [3:0]             target2,
	input  wire logic                   slot1_hit,
	input  wire logic                   slot2_hit,
	output logic      [N_RAIL-1:0][7:0] eff_byte
);

	wire sel1_ok = (target1 < TGT_LIMIT); // [R14]
	wire sel2_ok = (target2 < TGT_LIMIT); // [R14]

	for (genvar i = 0; i < N_RAIL; i++) begin : g_rail
		wire hit1 = slot1_hit && sel1_ok && (target1 == 4'(i)); // [R13]
		wire hit2 = slot2_hit && sel2_ok && (target2 == 4'(i)); // [R16]
		// Slot one wins when both slots aim at one regulator.
		assign eff_byte[i] = hit1 ? preset1 :
		                     hit2 ? preset2 : own_byte[i]; // [R15] [R17]
	end

endmodule // rcb_remap

// ==== core/rcb_regbank.sv ====
// Regulator control register bank with serial word-address port.
`timescale 1ns/1ps
module rcb_regbank
	import rcb_pkg::*;
(
	input  wire logic                     mclk,
	input  wire logic                     rst,
	input  wire logic                     addr_load,
	input  wire logic [7:0]               addr_byte,
	input  wire logic                     wr_stb,
	input  wire logic [7:0]               wr_data,
	input  wire logic                     rd_ack,
	output logic      [7:0]               rd_data,
	output logic      [7:0]               cur_addr,
	input  wire logic [NUM_BUCK-1:0]      buck_range_select,
	input  wire logic                     irq_level,
	input  wire logic                     supply_low,
	input  wire logic                     power_good,
	input  wire logic [NUM_PIN-1:0]       pin_in,
	output logic      [NUM_PIN-1:0]       pin_out,
	output logic      [NUM_PIN-1:0]       pin_oe_n,
	output logic      [NUM_PIN-1:0]       pin_pull_up,
	output logic      [NUM_PIN-1:0]       pin_pull_down,
	output logic      [NUM_PIN-1:0]       pin_irq_in,
	output logic      [NUM_PIN-1:0]       pin_standby_in,
	output logic      [NUM_RAIL-1:0]      rail_on,
	output logic      [NUM_BUCK-1:0][15:0] buck_level,
	output logic      [NUM_BUCK-1:0][1:0] buck_freq_code,
	output logic      [NUM_LIN-1:0][15:0] linear_level,
	output logic      [NUM_LIN-1:0]       linear_current_range,
	output logic      [NUM_LIN-1:0]       linear_code_bad
);

	logic [7:0]                addr_r;
	logic [7:0]                rd_data_r;
	logic [NUM_RAIL-1:0][7:0]  level_r;
	logic [NUM_PIN-1:0][7:0]   cfg_r;
	logic [6:0]                rail_en_r;
	logic [1:0]                out_bits_r;
	logic [7:0]                preset1_r;
	logic [7:0]                preset2_r;
	logic [7:0]                targets_r;
	logic [NUM_RAIL-1:0]       rail_on_r;
	logic [NUM_BUCK-1:0][15:0] buck_level_r;
	logic [NUM_BUCK-1:0][1:0]  buck_freq_r;
	logic [NUM_LIN-1:0][15:0]  lin_level_r;
	logic [NUM_LIN-1:0]        lin_range_r;
	logic [NUM_LIN-1:0]        lin_bad_r;
	logic [NUM_RAIL-1:0][7:0]  eff_byte;
	logic [NUM_PIN-1:0]        sampled;
	logic [NUM_PIN-1:0]        vsel_act;

	// Byte port sequencing; an address load takes precedence.
	wire       wr_go    = wr_stb && !addr_load;
	wire       rd_go    = rd_ack && !addr_load && !wr_stb;
	wire [7:0] addr_inc = addr_r + 8'h01;
	wire [7:0] addr_nxt = addr_load ? addr_byte :
	                      (wr_go || rd_go) ? addr_inc : addr_r; // [R18]

	wire hit_level = (addr_r >= OFF_LEVEL_FIRST) &&
	                 (addr_r <= OFF_LEVEL_LAST);
	wire hit_cfg1  = (addr_r == OFF_PIN1_CFG);
	wire hit_cfg2  = (addr_r == OFF_PIN2_CFG);
	wire hit_en    = (addr_r == OFF_RAIL_EN);
	wire hit_out   = (addr_r == OFF_PIN_OUT);
	wire hit_in    = (addr_r == OFF_PIN_IN);
	wire hit_pre1  = (addr_r == OFF_PRESET1);
	wire hit_pre2  = (addr_r == OFF_PRESET2);
	wire hit_tgt   = (addr_r == OFF_TARGETS);
	wire [2:0] lvl_idx = 3'(addr_r - OFF_LEVEL_FIRST);

	// Unmapped addresses and reserved bits read as zero.
	wire [7:0] rd_mux =
		hit_level ? level_r[lvl_idx] :
		hit_cfg1  ? cfg_r[0] :
		hit_cfg2  ? cfg_r[1] :
		hit_en    ? {1'b0, rail_en_r} :
		hit_out   ? {6'h00, out_bits_r} :
		hit_in    ? {6'h00, sampled} :
		hit_pre1  ? preset1_r :
		hit_pre2  ? preset2_r :
		hit_tgt   ? targets_r : 8'h00; // [R12] [R17]

	// Read data lags an address change by one edge.
	always_ff @(posedge mclk) begin
		if (rst) begin
			addr_r    <= 8'h00;
			rd_data_r <= 8'h00;
		end else begin
			addr_r    <= addr_nxt; // [R18]
			rd_data_r <= rd_mux;
		end
	end

	// Writes to the input bits or unmapped offsets only move the address.
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < NUM_RAIL; i++) begin
				level_r[i] <= RST_LEVEL;
			end
			cfg_r[0]   <= RST_PIN_CFG; // [R9]
			cfg_r[1]   <= RST_PIN_CFG; // [R9]
			rail_en_r  <= RST_RAIL_EN; // [R10]
			out_bits_r <= RST_PIN_OUT; // [R11]
			preset1_r  <= RST_PRESET;
			preset2_r  <= RST_PRESET;
			targets_r  <= RST_TARGETS; // [R14]
		end else if (wr_go) begin
			if (hit_level) begin
				level_r[lvl_idx] <= wr_data;
			end
			if (hit_cfg1) begin
				cfg_r[0] <= wr_data;
			end
			if (hit_cfg2) begin
				cfg_r[1] <= wr_data;
			end
			if (hit_en) begin
				rail_en_r <= wr_data[6:0];
			end
			if (hit_out) begin
				out_bits_r <= wr_data[1:0];
			end
			if (hit_pre1) begin
				preset1_r <= wr_data; // [R15]
			end
			if (hit_pre2) begin
				preset2_r <= wr_data; // [R15]
			end
			if (hit_tgt) begin
				targets_r <= wr_data;
			end
		end
	end

	for (genvar k = 0; k < NUM_PIN; k++) begin : g_pin
		rcb_pin_ctl u_pin (
			.mclk          (mclk),
			.rst           (rst),
			.cfg           (cfg_r[k]),
			.drive_value   (out_bits_r[k]),
			.irq_level     (irq_level),
			.supply_low    (supply_low),
			.power_good    (power_good),
			.pin_in        (pin_in[k]),
			.pin_out       (pin_out[k]),
			.pin_oe_n      (pin_oe_n[k]),
			.pull_up       (pin_pull_up[k]),
			.pull_down     (pin_pull_down[k]),
			.sampled_level (sampled[k]),
			.vsel_active   (vsel_act[k]),
			.irq_in        (pin_irq_in[k]),
			.standby_in    (pin_standby_in[k])
		);
	end

	// A lone select pin feeds both slots; two pins split them.
	wire slot1_hit = vsel_act[0] ? sampled[0] :
	                 (vsel_act[1] && sampled[1]); // [R8] [R13]
	wire slot2_hit = vsel_act[1] ? sampled[1] :
	                 (vsel_act[0] && sampled[0]); // [R8] [R16]

	rcb_remap #(
		.N_RAIL (NUM_RAIL)
	) u_remap (
		.own_byte  (level_r),
		.preset1   (preset1_r),
		.preset2   (preset2_r),
		.target1   (targets_r[TGT1_LSB +: 4]),
		.target2   (targets_r[TGT2_LSB +: 4]),
		.slot1_hit (slot1_hit),
		.slot2_hit (slot2_hit),
		.eff_byte  (eff_byte)
	);

	// Decodes are registered so rail outputs only move on a clock edge.
	for (genvar b = 0; b < NUM_BUCK; b++) begin : g_buck
		wire [6:0]  code = eff_byte[b][6:0];
		wire        fbit = eff_byte[b][LEVEL_TOP];
		wire [15:0] lv1  = BUCK_B1 + 16'(code) * BUCK_S1;
		wire [15:0] lv2  = BUCK_B2 + 16'(7'(code - BUCK_OFS2)) * BUCK_S2;
		wire [15:0] lv3  = BUCK_B3 + 16'(7'(code - BUCK_OFS3)) * BUCK_S3;
		wire [15:0] lv   = (code == 7'h00) ? 16'h0000 :
		                   (code < BUCK_SEG2) ? lv1 :
		                   (code < BUCK_SEG3) ? lv2 : lv3; // [R3]
		wire [1:0]  fc   = buck_range_select[b] ?
		                   (fbit ? FREQ_4MHZ : FREQ_3MHZ) :
		                   (fbit ? FREQ_3MHZ : FREQ_2MHZ); // [R1]
		wire        on   = rail_en_r[b] && (code != 7'h00); // [R2] [R10]
		always_ff @(posedge mclk) begin
			if (rst) begin
				buck_level_r[b] <= 16'h0000;
				buck_freq_r[b]  <= FREQ_2MHZ;
				rail_on_r[b]    <= 1'b0;
			end else begin
				buck_level_r[b] <= lv;
				buck_freq_r[b]  <= fc;
				rail_on_r[b]    <= on;
			end
		end
	end

	for (genvar j = 0; j < NUM_LIN; j++) begin : g_lin
		wire [6:0]  code = eff_byte[NUM_BUCK+j][6:0];
		// Forbidden gap codes keep the regulator off and are flagged.
		wire        bad  = (code >= LIN_GAP_LO) && (code < LIN_HI_OFS);
		wire [15:0] lv1  = LIN_B1 + 16'(code) * LIN_STEP;
		wire [15:0] lv2  = LIN_B2 + 16'(7'(code - LIN_HI_OFS)) * LIN_STEP;
		wire [15:0] lv   = (code == 7'h00 || bad) ? 16'h0000 :
		                   (code < LIN_HI_OFS) ? lv1 : lv2; // [R4]
		wire        on   = rail_en_r[NUM_BUCK+j] && (code != 7'h00) &&
		                   !bad; // [R4] [R10]
		always_ff @(posedge mclk) begin
			if (rst) begin
				lin_level_r[j]        <= 16'h0000;
				lin_range_r[j]        <= 1'b0;
				lin_bad_r[j]          <= 1'b0;
				rail_on_r[NUM_BUCK+j] <= 1'b0;
			end else begin
				lin_level_r[j]        <= lv;
				lin_range_r[j]        <= eff_byte[NUM_BUCK+j][LEVEL_TOP]; // [R5]
				lin_bad_r[j]          <= bad;
				rail_on_r[NUM_BUCK+j] <= on;
			end
		end
	end

	assign rd_data              = rd_data_r;
	assign cur_addr             = addr_r;
	assign rail_on              = rail_on_r;
	assign buck_level           = buck_level_r;
	assign buck_freq_code       = buck_freq_r;
	assign linear_level         = lin_level_r;
	assign linear_current_range = lin_range_r;
	assign linear_code_bad      = lin_bad_r;

	a_addr_incr: assert property (@(posedge mclk) disable iff (rst) // [R18]
		(wr_stb && !addr_load) |=> addr_r == 8'($past(addr_r) + 8'h01))
		else $error("word address did not advance");
	a_zero_off: assert property (@(posedge mclk) disable iff (rst) // [R2]
		(eff_byte[0][6:0] == 7'h00) |=> !rail_on[0])
		else $error("buck with zero code is on");
	a_global_off: assert property (@(posedge mclk) disable iff (rst) // [R10]
		!rail_en_r[0] |=> !rail_on[0] ##1 $past(rail_en_r[0]) || !rail_on[0])
		else $error("disabled rail is on");
	a_freq_map: assert property (@(posedge mclk) disable iff (rst) // [R1]
		(buck_range_select[1] && !eff_byte[1][7]) |=>
		buck_freq_code[1] == FREQ_3MHZ)
		else $error("frequency code wrong");
	a_buck_seg: assert property (@(posedge mclk) disable iff (rst) // [R3]
		(eff_byte[2][6:0] == 7'h41) |=> buck_level[2] == 16'h37aa)
		else $error("buck level segment two wrong");
	a_lin_gap: assert property (@(posedge mclk) disable iff (rst) // [R4]
		(eff_byte[5][6:0] == 7'h30) |=> !rail_on[5] && linear_code_bad[0])
		else $error("gap code not refused");
	a_lin_range: assert property (@(posedge mclk) disable iff (rst) // [R5]
		1'b1 |=> linear_current_range[1] == $past(eff_byte[6][7]))
		else $error("current range not followed");
	a_tgt_limit: assert property (@(posedge mclk) disable iff (rst) // [R14]
		(targets_r[3:0] >= TGT_LIMIT && targets_r[7:4] >= TGT_LIMIT) |->
		eff_byte == level_r)
		else $error("disabled slot still remaps");
	a_slot1_sub: assert property (@(posedge mclk) disable iff (rst) // [R13]
		(slot1_hit && targets_r[3:0] == 4'h0) |=>
		buck_level[0] == $past(g_buck[0].lv) &&
		$past(eff_byte[0]) == $past(preset1_r))
		else $error("slot one preset not used");
	a_in_ro: assert property (@(posedge mclk) disable iff (rst) // [R12]
		(wr_go && hit_in) |=> $stable(out_bits_r) && $stable(cfg_r))
		else $error("write to input bits had effect");

	a_freq_4m: assert property (@(posedge mclk) disable iff (rst) // [R1]
		(buck_range_select[3] && eff_byte[3][7]) |=>
		buck_freq_code[3] == FREQ_4MHZ)
		else $error("frequency code not top range");
	a_lin_off: assert property (@(posedge mclk) disable iff (rst) // [R4]
		(eff_byte[5][6:0] == 7'h00) |=>
		!rail_on[5] && linear_level[0] == 16'h0000)
		else $error("linear with zero code is on");
	a_slot2_sub: assert property (@(posedge mclk) disable iff (rst) // [R16]
		(slot2_hit && targets_r[7:4] == 4'h1 &&
		!(slot1_hit && targets_r[3:0] == 4'h1)) |-> eff_byte[1] == preset2_r)
		else $error("slot two preset not used");
	a_slot_idle: assert property (@(posedge mclk) disable iff (rst) // [R17]
		(!slot1_hit && !slot2_hit) |-> eff_byte == level_r)
		else $error("remap held after pin release");
	a_one_pin: assert property (@(posedge mclk) disable iff (rst) // [R8]
		(vsel_act[0] && !vsel_act[1]) |->
		slot1_hit == sampled[0] && slot2_hit == sampled[0])
		else $error("lone select pin does not feed both slots");
	a_two_pins: assert property (@(posedge mclk) disable iff (rst) // [R8]
		(vsel_act[0] && vsel_act[1]) |->
		slot1_hit == sampled[0] && slot2_hit == sampled[1])
		else $error("select pins do not split the slots");
	a_rsvd_en: assert property (@(posedge mclk) disable iff (rst) // [R17]
		hit_en |=> !rd_data[7])
		else $error("reserved enable bit reads one");
	a_rsvd_pin: assert property (@(posedge mclk) disable iff (rst) // [R17]
		(hit_out || hit_in) |=> rd_data[7:2] == 6'h00)
		else $error("reserved pin data bits read nonzero");
	a_preset_wr: assert property (@(posedge mclk) disable iff (rst) // [R15]
		(wr_go && hit_pre1) |=> preset1_r == $past(wr_data))
		else $error("preset byte not stored whole");

endmodule // rcb_regbank

// ==== test/rcb_host_model.sv ====
// Host model that drives the register port as the serial bus master would.
`timescale 1ns/1ps
module rcb_host_model (
	input  wire logic       mclk,
	output logic            addr_load,
	output logic      [7:0] addr_byte,
	output logic            wr_stb,
	output logic      [7:0] wr_data,
	output logic            rd_ack,
	input  wire logic [7:0] rd_data
);
	initial begin
		addr_load = 1'b0;
		addr_byte = 8'h00;
		wr_stb = 1'b0;
		wr_data = 8'h00;
		rd_ack = 1'b0;
	end

	// Word-address phase; returns at the falling edge after it is taken.
	task automatic seek(input logic [7:0] a);
		@(negedge mclk);
		addr_load = 1'b1;
		addr_byte = a;
		@(negedge mclk);
		addr_load = 1'b0;
		addr_byte = ~a;
	endtask

	// Bytes go back to back to consecutive word addresses.
	task automatic wr(input logic [7:0] a, input logic [63:0] d, input int n);
		seek(a);
		for (int i = 0; i < n; i++) begin
			wr_stb = 1'b1;
			wr_data = d[8*i +: 8];
			@(negedge mclk);
		end
		wr_stb = 1'b0;
		wr_data = 8'h5a;
	endtask

	// Sequential read; each consumed byte is acknowledged.
	task automatic rd(input logic [7:0] a, input int n, output logic [63:0] d);
		d = '0;
		seek(a);
		for (int i = 0; i < n; i++) begin
			@(negedge mclk);
			d[8*i +: 8] = rd_data;
			rd_ack = 1'b1;
			@(negedge mclk);
			rd_ack = 1'b0;
		end
	endtask
endmodule // rcb_host_model

// ==== test/rcb_regbank_tb.sv ====
// Self-checking bench for the regulator control register bank.
`timescale 1ns/1ps
module rcb_regbank_tb;
	import rcb_pkg::*;
	logic                     mclk, rst, addr_load, wr_stb, rd_ack;
	logic                     irq_level, supply_low, power_good;
	logic [7:0]               addr_byte, wr_data, rd_data, cur_addr;
	logic [NUM_BUCK-1:0]      range_sel;
	logic [NUM_PIN-1:0]       ext_lvl, pin_wire, pin_out, pin_oe_n;
	logic [NUM_PIN-1:0]       pull_up, pull_dn, irq_in, stby_in;
	logic [NUM_RAIL-1:0]      rail_on;
	logic [NUM_BUCK-1:0][15:0] buck_level;
	logic [NUM_BUCK-1:0][1:0] buck_freq;
	logic [NUM_LIN-1:0][15:0] lin_level;
	logic [NUM_LIN-1:0]       lin_range, lin_bad;
	logic [63:0]              rv;
	logic [63:0]              bd = 64'h7ff0c14001;
	logic [1:0]               fx [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h0};
	logic [3:0]               fn [3] = '{4'h1, 4'h2, 4'h7};
	logic [7:0]               ra [16] = '{8'h00, 8'h01, 8'h02, 8'h03,
		8'h04, 8'h05, 8'h06, 8'h0c, 8'h0d, 8'h10, 8'h20, 8'h21, 8'h22,
		8'h23, 8'h24, 8'h30};
	logic [7:0]               rx [16] = '{8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h03, 8'h03, 8'h7f, 8'h00, 8'h00, 8'h00,
		8'h00, 8'hff, 8'h00};
	int                       error_cnt, tests_run;

	// A released pin follows the external level; a driving pin wins.
	assign pin_wire = (pin_oe_n & ext_lvl) | (~pin_oe_n & pin_out);

	rcb_host_model u_host (.mclk(mclk), .addr_load(addr_load),
		.addr_byte(addr_byte), .wr_stb(wr_stb), .wr_data(wr_data),
		.rd_ack(rd_ack), .rd_data(rd_data));

	rcb_regbank u_dut (.mclk(mclk), .rst(rst), .addr_load(addr_load),
		.addr_byte(addr_byte), .wr_stb(wr_stb), .wr_data(wr_data),
		.rd_ack(rd_ack), .rd_data(rd_data), .cur_addr(cur_addr),
		.buck_range_select(range_sel), .irq_level(irq_level),
		.supply_low(supply_low), .power_good(power_good),
		.pin_in(pin_wire), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.pin_pull_up(pull_up), .pin_pull_down(pull_dn),
		.pin_irq_in(irq_in), .pin_standby_in(stby_in), .rail_on(rail_on),
		.buck_level(buck_level), .buck_freq_code(buck_freq),
		.linear_level(lin_level), .linear_current_range(lin_range),
		.linear_code_bad(lin_bad));

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic results;
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Expected buck output in units of 0.1 mV.
	function automatic logic [15:0] bv(input logic [6:0] c);
		logic [15:0] k;
		k = {9'h0, c};
		if (c == 7'h00)
			return 16'h0000;
		else if (c <= 7'h40)
			return 16'h1770 + k * 16'h007d;
		else if (c <= 7'h70)
			return 16'h36b0 + (k - 16'h0040) * 16'h00fa;
		return 16'h6590 + (k - 16'h0070) * 16'h01f4;
	endfunction

	// Packs {wire, oe_n, pull_up, pull_down, input bit} of the first pin.
	task automatic pin_case(input logic [7:0] cfg, input logic ob,
		input logic ext, input logic [4:0] exp);
		ext_lvl[0] = ext;
		u_host.wr(8'h0c, {56'h0, cfg}, 1);
		u_host.wr(8'h20, {63'h0, ob}, 1);
		repeat (3) @(negedge mclk);
		u_host.rd(8'h21, 1, rv);
		chk({11'h0, pin_wire[0], pin_oe_n[0], pull_up[0], pull_dn[0],
			rv[0]}, {11'h0, exp});
	endtask

	task automatic remap_case(input logic [1:0] ext, input logic [15:0] e0,
		input logic [15:0] e1);
		ext_lvl = ext;
		repeat (4) @(negedge mclk);
		chk(buck_level[0], e0);
		chk(buck_level[1], e1);
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		error_cnt++;
		$display("BAD t=%0t run did not finish", $time);
		results;
	end

	initial begin
		rst = 1'b1;
		range_sel = 5'h0a;
		irq_level = 1'b0;
		supply_low = 1'b0;
		power_good = 1'b0;
		ext_lvl = 2'h0;
		error_cnt = 0;
		tests_run = 0;
		repeat (20) @(negedge mclk);
		rst = 1'b0;
		u_host.wr(8'h21, 64'hff, 1);
		for (int i = 0; i < 16; i++) begin
			u_host.rd(ra[i], 1, rv);
			chk({8'h0, rv[7:0]}, {8'h0, rx[i]});
		end
		chk({9'h0, rail_on}, 16'h0000);
		$display("test reset values done");

		u_host.wr(8'h00, bd, 5);
		repeat (3) @(negedge mclk);
		u_host.rd(8'h00, 5, rv);
		chk({8'h0, cur_addr}, 16'h0005);
		for (int i = 0; i < NUM_BUCK; i++) begin
			chk({8'h0, rv[8*i +: 8]}, {8'h0, bd[8*i +: 8]});
			chk(buck_level[i], bv(bd[8*i +: 7]));
			chk({14'h0, buck_freq[i]}, {14'h0, fx[i]});
		end
		$display("test buck codes done");

		// Only legal linear codes are written.
		u_host.wr(8'h05, 64'h7fa4, 2);
		repeat (3) @(negedge mclk);
		chk(lin_level[0], 16'h1f40 + 16'h0024 * 16'h00fa);
		chk(lin_level[1], 16'h4362 + 16'h003f * 16'h00fa);
		chk({12'h0, lin_range, lin_bad}, 16'h0004);
		u_host.wr(8'h10, 64'hfe, 1);
		repeat (3) @(negedge mclk);
		chk({9'h0, rail_on}, 16'h007e);
		u_host.rd(8'h10, 1, rv);
		chk({8'h0, rv[7:0]}, 16'h007e);
		u_host.wr(8'h10, 64'hff, 1);
		$display("test linear and enables done");

		pin_case(8'h01, 1'b1, 1'b0, 5'b10000);
		pin_case(8'h81, 1'b1, 1'b1, 5'b00000);
		pin_case(8'h04, 1'b0, 1'b1, 5'b11101);
		pin_case(8'h85, 1'b0, 1'b1, 5'b11010);
		pin_case(8'h02, 1'b0, 1'b1, 5'b00000);
		pin_case(8'h06, 1'b1, 1'b1, 5'b11101);
		pin_case(8'h18, 1'b0, 1'b1, 5'b11001);
		chk({15'h0, irq_in[0]}, 16'h0001);
		for (int f = 0; f < 3; f++) begin
			for (int l = 0; l < 2; l++) begin
				{irq_level, supply_low, power_good} =
					(l == 1) ? (3'h4 >> f) : ~(3'h4 >> f);
				pin_case({1'b0, fn[f], 3'h1}, 1'b0, 1'b0,
					{l[0], 4'h0});
			end
		end
		$display("test pins done");

		u_host.wr(8'h22, 64'h1071_85, 3);
		u_host.wr(8'h0c, 64'h28, 1);
		u_host.wr(8'h0d, 64'h00, 1);
		remap_case(2'b01, bv(7'h05), bv(7'h71));
		chk({14'h0, buck_freq[0]}, 16'h0001);
		remap_case(2'b00, bv(7'h01), bv(7'h40));
		u_host.wr(8'h0d, 64'h30, 1);
		remap_case(2'b01, bv(7'h05), bv(7'h40));
		remap_case(2'b10, bv(7'h01), bv(7'h71));
		chk({15'h0, stby_in[1]}, 16'h0001);
		u_host.wr(8'h24, 64'h1c, 1);
		remap_case(2'b11, bv(7'h01), bv(7'h71));
		$display("test remapping done");
		results;
	end
endmodule // rcb_regbank_tb
